// ===== sim/pcs_checker.sv
/* Assertions on the control and condition register ports.
   Assumes it is bound to pcs_cmd_status_regs. */
`timescale 1ns/1ps
module pcs_checker (
  input wire logic clk_sys, // Clock
  input wire logic nrst, // Reset
  input wire logic cfg_rd, // Read strobe
  input wire logic cfg_wr, // Write strobe
  input wire logic [7:0] cfg_addr, // Address
  input wire logic [3:0] cfg_be, // Byte enables
  input wire logic [31:0] cfg_wdata, // Write data
  input wire logic [31:0] cfg_rdata, // Read data
  input wire logic addr_parity_err, // Event
  input wire logic data_parity_err, // Event
  input wire logic serr_request, // Event
  input wire logic perr_request, // Event
  input wire logic initiator_abort_evt, // Event
  input wire logic serr_drive, // Output
  input wire logic perr_drive, // Output
  input wire logic write_invalidate_enable, // Output
  input wire logic bus_initiator_enable, // Output
  input wire logic memory_space_enable // Output
);
  // ****
  // Port relations
  // ****
  logic hit;
  logic [2:0] ens;
  assign hit = cfg_addr[7:2] == 6'h01;
  assign ens = {write_invalidate_enable, bus_initiator_enable, memory_space_enable};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_fixed_bits_read: assert property (
    cfg_rd && hit |=> (cfg_rdata & 32'h06ff_fea9) == 32'h0210_0000)
    else $error("fixed bits wrong");
  a_enables_follow: assert property (
    cfg_wr && hit && cfg_be[0] |=> ens == {$past(cfg_wdata[4]), $past(cfg_wdata[2]), $past(cfg_wdata[1])})
    else $error("enables differ from write");
  a_enables_hold: assert property (!(cfg_wr && hit && cfg_be[0]) |=> $stable(ens))
    else $error("enables moved");
  a_serr_gated: assert property (serr_drive |-> $past(serr_request))
    else $error("system error driven unasked");
  a_perr_gated: assert property (perr_drive |-> $past(perr_request))
    else $error("parity error driven unasked");
  a_serr_flag_set: assert property (serr_drive && cfg_rd && hit |=> cfg_rdata[30])
    else $error("system error flag missing");
  a_abort_flag_set: assert property (initiator_abort_evt ##1 (cfg_rd && hit) |=> cfg_rdata[29])
    else $error("master abort flag missing");
  a_parity_flag_set: assert property (
    (addr_parity_err || data_parity_err) ##1 (cfg_rd && hit) |=> cfg_rdata[31])
    else $error("parity flag missing");
  c_write: cover property (cfg_wr && hit);
  c_serr: cover property (serr_drive);
  c_perr: cover property (perr_drive);
endmodule : pcs_checker

bind pcs_cmd_status_regs pcs_checker pcs_checker_inst (.clk_sys(clk_sys), .nrst(nrst), .cfg_rd(cfg_rd),
  .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
  .addr_parity_err(addr_parity_err), .data_parity_err(data_parity_err), .serr_request(serr_request),
  .perr_request(perr_request), .initiator_abort_evt(initiator_abort_evt), .serr_drive(serr_drive),
  .perr_drive(perr_drive), .write_invalidate_enable(write_invalidate_enable),
  .bus_initiator_enable(bus_initiator_enable), .memory_space_enable(memory_space_enable));

// ===== sim/pcs_link_model.sv
/* Link-side model raising bus events on request.
   Assumes the bench pulses kick for one clk_sys cycle. */
`timescale 1ns/1ps
module pcs_link_model (
  input wire logic clk_sys, // Clock
  input wire logic nrst, // Reset
  input wire logic [7:0] kick, // Event request
  input wire logic bus_initiator_enable, // Device may initiate
  output logic [7:0] evt // Registered events
);
  // ****
  // Event launch
  // ****
  // No initiator-side event while initiating is barred
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      evt <= 8'h00;
    end else begin
      evt <= kick & (bus_initiator_enable ? 8'hff : 8'h8f);
    end
  end
endmodule : pcs_link_model

// ===== sim/testbench.sv
/* Self-checking bench for the control and condition registers.
   Assumes the link model and checker are compiled first. */
`timescale 1ns/1ps
module testbench;
  import pcs_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic cfg_rd = 1'b0;
  logic cfg_wr = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [3:0] cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0;
  logic [7:0] kick = 8'h00;
  logic [7:0] evt;
  logic [31:0] cfg_rdata, rdv;
  logic cfg_ack, serr_drive, perr_drive, wie, bie, mse;
  logic [39:0] tbl [11];
  int err_total = 0;
  int compares = 0;
  int cycles = 0;
  int serr_n = 0;
  int perr_n = 0;
  int s0, p0;
  pcs_cmd_status_regs pcs_cmd_status_regs_inst (.clk_sys(clk_sys), .nrst(nrst), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
    .addr_parity_err(evt[0]), .data_parity_err(evt[1]), .serr_request(evt[2]), .perr_request(evt[3]),
    .perr_seen(evt[4]), .initiator_phase(evt[4]), .initiator_abort_evt(evt[5]), .target_abort_rcvd_evt(evt[6]),
    .target_abort_sig_evt(evt[7]), .serr_drive(serr_drive), .perr_drive(perr_drive),
    .write_invalidate_enable(wie), .bus_initiator_enable(bie), .memory_space_enable(mse));
  pcs_link_model pcs_link_model_inst (.clk_sys(clk_sys), .nrst(nrst), .kick(kick), .bus_initiator_enable(bie),
    .evt(evt));
  // ****
  // Clock, watchdog and tasks
  // ****
  initial forever #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    serr_n += serr_drive;
    perr_n += perr_drive;
    if (cycles == 3000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic acc(input logic rd, input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd);
    @(posedge clk_sys);
    cfg_rd <= rd;
    cfg_wr <= !rd;
    cfg_addr <= a;
    cfg_be <= be;
    cfg_wdata <= wd;
    kick <= 8'h00;
    @(posedge clk_sys);
    cfg_rd <= 1'b0;
    cfg_wr <= 1'b0;
    #1;
    chk("ack", {31'h0, cfg_ack}, 32'h1);
    rdv = cfg_rdata;
  endtask : acc
  task automatic rd_chk(input string name, input logic [31:0] exp);
    acc(1'b1, 8'h04, 4'h0, 32'h0);
    chk(name, rdv, exp);
  endtask : rd_chk
  task automatic end_of_test();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test
  // ****
  // Tests: {event request, control value, flag raised}
  // ****
  initial begin
    tbl = '{40'h01_0156_8000, 40'h02_0156_8000, 40'h04_0156_4000, 40'h04_0056_0000, 40'h08_0156_0000,
      40'h08_0116_0000, 40'h10_0156_0100, 40'h10_0116_0000, 40'h20_0156_2000, 40'h40_0156_1000, 40'h80_0156_0800};
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    rd_chk("reset", 32'h0210_0000);
    acc(1'b0, 8'h04, 4'hf, 32'hffff_ffff);
    rd_chk("ones", 32'h0210_0156);
    chk("enables", {29'h0, wie, bie, mse}, 32'h7);
    acc(1'b0, 8'h06, 4'h2, 32'h0);
    rd_chk("lane", 32'h0210_0056);
    acc(1'b1, 8'h40, 4'h0, 32'h0);
    chk("unmapped", rdv, 32'h0);
    $display("register test done");
    foreach (tbl[i]) begin
      acc(1'b0, 8'h04, 4'h3, {16'h0, tbl[i][31:16]});
      s0 = serr_n;
      p0 = perr_n;
      @(posedge clk_sys);
      kick <= tbl[i][39:32];
      @(posedge clk_sys);
      kick <= 8'h00;
      rd_chk("flag", {16'h0210 | tbl[i][15:0], tbl[i][31:16]});
      chk("drive", 32'((perr_n - p0) * 2 + serr_n - s0),
        {30'h0, tbl[i][35] & tbl[i][22], tbl[i][34] & tbl[i][24]});
      acc(1'b0, 8'h04, 4'hc, {~tbl[i][15:0], 16'h0});
      rd_chk("kept", {16'h0210 | tbl[i][15:0], tbl[i][31:16]});
      acc(1'b0, 8'h04, 4'hc, {tbl[i][15:0], 16'h0});
      rd_chk("cleared", {16'h0210, tbl[i][31:16]});
    end
    @(posedge clk_sys);
    kick <= 8'h80;
    acc(1'b0, 8'h04, 4'h8, 32'h0800_0000);
    rd_chk("set wins", 32'h0a10_0156);
    $display("event test done");
    end_of_test();
  end
endmodule : testbench

// ===== verilog/pcs_cmd_status_regs.sv
/*
 * Bus interface control and condition registers of the configuration header.
 * Assumes configuration reads and writes arrive as one-cycle strobes on clk_sys
 * and that bus events come from link logic on the same clock.
 */
`timescale 1ns/1ps
// Overview of operation
// - Control bits 15 to 10 read zero.
// - Back-to-back issue enable, bit 9, is read-only zero.
// - Bit 8 writable; enables driving system error when the link requests it.
// - Stepping control, bit 7, is hardwired zero.
// - Bit 6 writable; gates driving of the parity error response.
// - Palette snoop enable, bit 5, reads zero.
// - Bit 4 writable; allows write-and-invalidate commands, else plain writes.
// - Special cycle enable, bit 3, reads zero.
// - Bit 2 writable; initiating bus cycles only while set.
// - Bit 1 writable; claims memory cycles, software sets it before register access.
// - Port space enable, bit 0, reads zero.
// - Condition bit 15 sticks on address or data parity error.
// - Bit 14 sets when system error was driven while enabled.
// - Bit 13 sets when an initiated cycle ends in master abort.
// - Bit 12 sets when an initiated cycle gets target abort.
// - Bit 11 sets when the device as target signals target abort.
// - Bits 10 to 9 fixed at binary 01, medium decode timing.
// - Bit 8 sets on parity error seen, initiator phase, response enabled.
// - Bits 7 and 6 are hardwired zero.
// - Bit 5 reads zero; not high clock capable.
// - Bit 4 reads one; capability chain present.
// - Condition bits 3 to 0 read zero.
// - Error flags clear only on a write of one; zero leaves them.
module pcs_cmd_status_regs
  import pcs_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic cfg_rd, // Configuration read strobe
  input wire logic cfg_wr, // Configuration write strobe
  input wire logic [7:0] cfg_addr, // Configuration byte address
  input wire logic [3:0] cfg_be, // Byte enables, active high
  input wire logic [31:0] cfg_wdata, // Write data
  output logic [31:0] cfg_rdata, // Read data, registered
  output logic cfg_ack, // Access done, one cycle
  input wire logic addr_parity_err, // Address parity error seen
  input wire logic data_parity_err, // Data parity error seen
  input wire logic serr_request, // Link wants to raise system error
  input wire logic perr_request, // Link wants to raise parity error
  input wire logic perr_seen, // Parity error line asserted by any agent
  input wire logic initiator_phase, // Device was initiator of this data phase
  input wire logic initiator_abort_evt, // Own cycle ended in master abort
  input wire logic target_abort_rcvd_evt, // Own cycle got target abort
  input wire logic target_abort_sig_evt, // Device signalled target abort
  output logic serr_drive, // Drive system error line
  output logic perr_drive, // Drive parity error line
  output logic write_invalidate_enable, // May issue write-and-invalidate
  output logic bus_initiator_enable, // May initiate cycles
  output logic memory_space_enable // May claim memory cycles
);

  // ****************************************************************
  // Decode
  // ****************************************************************
  function automatic logic hits_dword(input logic [7:0] addr);
    hits_dword = (addr & PCS_DWORD_MASK) == PCS_CTRL_OFFSET;
  endfunction : hits_dword

  logic wr_hit;
  logic rd_hit;
  assign wr_hit = cfg_wr & hits_dword(cfg_addr);
  assign rd_hit = cfg_rd & hits_dword(cfg_addr);

  // ****************************************************************
  // Control register
  // ****************************************************************
  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic [15:0] wr_lanes;

  always_comb begin
    wr_lanes = {{8{cfg_be[1]}}, {8{cfg_be[0]}}};
    ctrl_next = ctrl_reg;
    if (wr_hit) begin
      ctrl_next = (ctrl_reg & ~wr_lanes) | (cfg_wdata[15:0] & wr_lanes);
    end
    // Only bits 8, 6, 4, 2, 1 store; the rest stay zero
    ctrl_next = ctrl_next & PCS_CTRL_RW_MASK;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= PCS_CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  logic serr_en;
  logic perr_en;
  assign serr_en = ctrl_reg[PCS_CTRL_SYSTEM_ERROR_DRIVER_ENABLE];
  assign perr_en = ctrl_reg[PCS_CTRL_PARITY_RESPONSE_ENABLE];

  // ****************************************************************
  // Enables to the link logic
  // ****************************************************************
  // Registered so the pin enable never glitches with the request
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      serr_drive <= 1'b0;
    end else begin
      serr_drive <= serr_request & serr_en;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      perr_drive <= 1'b0;
    end else begin
      perr_drive <= perr_request & perr_en;
    end
  end

  assign write_invalidate_enable = ctrl_reg[PCS_CTRL_WRITE_INVALIDATE_ENABLE];
  assign bus_initiator_enable = ctrl_reg[PCS_CTRL_BUS_INITIATOR_ENABLE];
  // Link must not claim memory cycles before software sets this
  assign memory_space_enable = ctrl_reg[PCS_CTRL_MEMORY_SPACE_ENABLE];

  // ****************************************************************
  // Control read view
  // ****************************************************************
  // Unsupported features read zero whatever was written
  logic [5:0] ctrl_reserved_high;
  logic back_to_back_issue_enable;
  logic system_error_driver_enable;
  logic stepping_control;
  logic parity_response_enable;
  logic palette_snoop_enable;
  logic special_cycle_enable;
  logic port_space_enable;
  logic [15:0] ctrl_read;

  assign ctrl_reserved_high = 6'h00;
  assign back_to_back_issue_enable = 1'b0;
  assign system_error_driver_enable = serr_en;
  assign stepping_control = 1'b0;
  assign parity_response_enable = perr_en;
  assign palette_snoop_enable = 1'b0;
  assign special_cycle_enable = 1'b0;
  assign port_space_enable = 1'b0;

  // Order must follow the field positions of the package
  assign ctrl_read = {
    ctrl_reserved_high,
    back_to_back_issue_enable,
    system_error_driver_enable,
    stepping_control,
    parity_response_enable,
    palette_snoop_enable,
    write_invalidate_enable,
    special_cycle_enable,
    bus_initiator_enable,
    memory_space_enable,
    port_space_enable
  };

  // ****************************************************************
  // Condition flags
  // ****************************************************************
  logic [PCS_FLAG_COUNT-1:0] flag_set;
  logic [PCS_FLAG_COUNT-1:0] flag_val;
  logic [15:0] clr_bits;

  assign flag_set[0] = perr_seen & initiator_phase & perr_en;
  assign flag_set[1] = target_abort_sig_evt;
  assign flag_set[2] = target_abort_rcvd_evt;
  assign flag_set[3] = initiator_abort_evt;
  // Counted as signalled when the line is really driven
  assign flag_set[4] = serr_request & serr_en;
  assign flag_set[5] = addr_parity_err | data_parity_err;

  // Clear by writing one in the upper status lanes
  assign clr_bits = wr_hit ? (cfg_wdata[31:16] & {{8{cfg_be[3]}}, {8{cfg_be[2]}}}) : 16'h0000;

  pcs_sticky_flag u_initiator_parity_flag (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .set_evt(flag_set[0]),
    .clr_req(clr_bits[PCS_COND_INITIATOR_DATA_PARITY_FLAG]),
    .flag(flag_val[0])
  );

  pcs_sticky_flag u_signalled_abort_flag (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .set_evt(flag_set[1]),
    .clr_req(clr_bits[PCS_COND_SIGNALLED_TARGET_ABORT_FLAG]),
    .flag(flag_val[1])
  );

  pcs_sticky_flag u_received_abort_flag (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .set_evt(flag_set[2]),
    .clr_req(clr_bits[PCS_COND_RECEIVED_TARGET_ABORT_FLAG]),
    .flag(flag_val[2])
  );

  pcs_sticky_flag u_initiator_abort_flag (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .set_evt(flag_set[3]),
    .clr_req(clr_bits[PCS_COND_RECEIVED_INITIATOR_ABORT_FLAG]),
    .flag(flag_val[3])
  );

  pcs_sticky_flag u_system_error_flag (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .set_evt(flag_set[4]),
    .clr_req(clr_bits[PCS_COND_SIGNALLED_SYSTEM_ERROR_FLAG]),
    .flag(flag_val[4])
  );

  pcs_sticky_flag u_parity_flag (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .set_evt(flag_set[5]),
    .clr_req(clr_bits[PCS_COND_DETECTED_PARITY_ERROR_FLAG]),
    .flag(flag_val[5])
  );

  // ****************************************************************
  // Condition read view
  // ****************************************************************
  logic detected_parity_error_flag;
  logic signalled_system_error_flag;
  logic received_initiator_abort_flag;
  logic received_target_abort_flag;
  logic signalled_target_abort_flag;
  logic [1:0] devsel_timing;
  logic initiator_data_parity_flag;
  logic back_to_back_accept_capable;
  logic user_feature_support_flag;
  logic high_clock_capable;
  logic capability_chain_present;
  logic [3:0] cond_reserved_low;
  logic [15:0] cond_val;

  assign detected_parity_error_flag = flag_val[5];
  assign signalled_system_error_flag = flag_val[4];
  assign received_initiator_abort_flag = flag_val[3];
  assign received_target_abort_flag = flag_val[2];
  assign signalled_target_abort_flag = flag_val[1];
  assign devsel_timing = PCS_COND_DEVSEL_MEDIUM;
  assign initiator_data_parity_flag = flag_val[0];
  assign back_to_back_accept_capable = 1'b0;
  assign user_feature_support_flag = 1'b0;
  assign high_clock_capable = 1'b0;
  assign capability_chain_present = PCS_COND_FIXED[PCS_COND_CAPABILITY_CHAIN_PRESENT];
  assign cond_reserved_low = 4'h0;

  // Order must follow the field positions of the package
  assign cond_val = {
    detected_parity_error_flag,
    signalled_system_error_flag,
    received_initiator_abort_flag,
    received_target_abort_flag,
    signalled_target_abort_flag,
    devsel_timing,
    initiator_data_parity_flag,
    back_to_back_accept_capable,
    user_feature_support_flag,
    high_clock_capable,
    capability_chain_present,
    cond_reserved_low
  };

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Every access is acknowledged, mapped or not, so the host never stalls
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cfg_ack <= 1'b0;
    end else begin
      cfg_ack <= cfg_rd | cfg_wr;
    end
  end

  // Read data holds between reads; a write in the same cycle is seen next read
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cfg_rdata <= 32'h0000_0000;
    end else if (rd_hit) begin
      cfg_rdata <= {cond_val, ctrl_read};
    end else if (cfg_rd) begin
      // Other dwords belong elsewhere; this block answers zero
      cfg_rdata <= 32'h0000_0000;
    end
  end

endmodule : pcs_cmd_status_regs

// ===== verilog/pcs_pkg.sv
/*
 * Package for the bus interface control and condition registers.
 * Holds the configuration offsets, field positions, fixed values and reset values.
 * Assumes one configuration dword carries both 16-bit registers.
 */
package pcs_pkg;

  // ****************************************************************
  // Configuration space placement
  // ****************************************************************
  localparam logic [7:0] PCS_CTRL_OFFSET = 8'h04;
  localparam logic [7:0] PCS_COND_OFFSET = 8'h06;
  localparam logic [7:0] PCS_DWORD_MASK = 8'hfc;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int PCS_CTRL_BACK_TO_BACK_ISSUE_ENABLE = 9;
  localparam int PCS_CTRL_SYSTEM_ERROR_DRIVER_ENABLE = 8;
  localparam int PCS_CTRL_STEPPING_CONTROL = 7;
  localparam int PCS_CTRL_PARITY_RESPONSE_ENABLE = 6;
  localparam int PCS_CTRL_PALETTE_SNOOP_ENABLE = 5;
  localparam int PCS_CTRL_WRITE_INVALIDATE_ENABLE = 4;
  localparam int PCS_CTRL_SPECIAL_CYCLE_ENABLE = 3;
  localparam int PCS_CTRL_BUS_INITIATOR_ENABLE = 2;
  localparam int PCS_CTRL_MEMORY_SPACE_ENABLE = 1;
  localparam int PCS_CTRL_PORT_SPACE_ENABLE = 0;
  localparam logic [15:0] PCS_CTRL_RW_MASK = 16'h0156;
  localparam logic [15:0] PCS_CTRL_RESET = 16'h0000;

  // ****************************************************************
  // Condition register fields
  // ****************************************************************
  localparam int PCS_COND_DETECTED_PARITY_ERROR_FLAG = 15;
  localparam int PCS_COND_SIGNALLED_SYSTEM_ERROR_FLAG = 14;
  localparam int PCS_COND_RECEIVED_INITIATOR_ABORT_FLAG = 13;
  localparam int PCS_COND_RECEIVED_TARGET_ABORT_FLAG = 12;
  localparam int PCS_COND_SIGNALLED_TARGET_ABORT_FLAG = 11;
  localparam int PCS_COND_DEVSEL_TIMING_LSB = 9;
  localparam int PCS_COND_INITIATOR_DATA_PARITY_FLAG = 8;
  localparam int PCS_COND_BACK_TO_BACK_ACCEPT_CAPABLE = 7;
  localparam int PCS_COND_USER_FEATURE_SUPPORT_FLAG = 6;
  localparam int PCS_COND_HIGH_CLOCK_CAPABLE = 5;
  localparam int PCS_COND_CAPABILITY_CHAIN_PRESENT = 4;
  localparam logic [1:0] PCS_COND_DEVSEL_MEDIUM = 2'h1;
  localparam logic [15:0] PCS_COND_FIXED = 16'h0210;
  localparam logic [15:0] PCS_COND_RESET = 16'h0210;
  localparam int PCS_FLAG_COUNT = 6;

endpackage : pcs_pkg

// ===== verilog/pcs_sticky_flag.sv
/*
 * One sticky error flag: set by hardware, cleared by a write of one.
 * Assumes set and clear come from logic on the same clock.
 */
`timescale 1ns/1ps
module pcs_sticky_flag (
  input wire logic clk_sys, // System clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic set_evt, // Hardware event, one cycle
  input wire logic clr_req, // Software write of one
  output logic flag // Current flag value
);

  logic flag_reg;
  logic flag_next;

  // Set beats clear so an event in the clearing cycle is kept
  always_comb begin
    flag_next = set_evt | (flag_reg & ~clr_req);
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag = flag_reg;

endmodule : pcs_sticky_flag
